// [verilog/sxe_defs.vh]
// sxe_defs.vh: offsets, fields, opcodes and reset values of the
// skip / table read / xor execution block.
// assumes: included by the design file only, bare name.
`ifndef SXE_DEFS_VH
`define SXE_DEFS_VH
// =============================================
// register byte offsets
`define SXE_OFS_INSTR 12'h000
`define SXE_OFS_ACC 12'h004
`define SXE_OFS_STATUS 12'h008
`define SXE_OFS_TABLE_POINTER 12'h00c
`define SXE_OFS_TABLE_HIGH 12'h010
`define SXE_OFS_PAGE 12'h014
// data memory window: byte address base + 4 * memory address
`define SXE_MEM_BASE_SEL 2'h1
// =============================================
// instruction register fields
`define SXE_OP_LSB 0
`define SXE_OP_MSB 3
`define SXE_BIT_LSB 4
`define SXE_BIT_MSB 6
`define SXE_ADDR_LSB 8
`define SXE_ADDR_MSB 15
`define SXE_IMM_LSB 16
`define SXE_IMM_MSB 23
// status bits
`define SXE_ST_ZERO 0
`define SXE_ST_SKIP 1
`define SXE_ST_BUSY 2
// =============================================
// opcodes
`define SXE_OP_SKIP_ZERO 4'h0
`define SXE_OP_MOVE_SKIP 4'h1
`define SXE_OP_SZBIT 4'h2
`define SXE_OP_TRDC 4'h3
`define SXE_OP_TRDL 4'h4
`define SXE_OP_XORA 4'h5
`define SXE_OP_XOR_TO_MEM 4'h6
`define SXE_OP_XORI 4'h7
// =============================================
// reset values
`define SXE_RST_INSTR 24'h00_0000
`define SXE_RST_ACC 8'h00
`define SXE_RST_TABLE_POINTER 8'h00
`define SXE_RST_TABLE_HIGH 8'h00
`define SXE_RST_PAGE 5'h00
`endif

// [verilog/sxe_exec.v]
// sxe_exec.v: execution unit for skip-if-zero tests, program table reads
// and xor operations, with an apb register slave and its own data memory.
// assumes: one clock pclk, program rom on the same clock returning data
// on the same edge on which it samples prog_addr with prog_rd high.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sxe_defs.vh"

module sxe_exec #(
  parameter MEM_AW = 8,
  parameter PAGE_W = 5
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // program memory
  output reg [PAGE_W+7:0] prog_addr,
  output reg prog_rd,
  input wire [15:0] prog_rdata,
  // fetch pipeline
  output reg skip_next,
  output reg dummy_cycle,
  output reg busy
);

  // =============================================
  // state
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_EXEC = 3'd1;
  localparam [2:0] ST_DUMMY = 3'd2;
  localparam [2:0] ST_TWAIT = 3'd3;
  localparam [2:0] ST_TDATA = 3'd4;
  // the last program page is the one with every page bit set
  localparam [PAGE_W-1:0] LAST_PAGE = {PAGE_W{1'b1}};

  reg [2:0] state_reg;
  reg [23:0] instr_reg;
  reg [7:0] acc_reg;
  reg zero_reg;
  reg [7:0] table_pointer_reg;
  reg [7:0] table_high_latch_reg;
  reg [PAGE_W-1:0] page_reg;
  reg [7:0] dmem [0:(1<<MEM_AW)-1];

  wire [3:0] op = instr_reg[`SXE_OP_MSB:`SXE_OP_LSB];
  wire [2:0] bsel = instr_reg[`SXE_BIT_MSB:`SXE_BIT_LSB];
  wire [MEM_AW-1:0] maddr = instr_reg[`SXE_ADDR_LSB+MEM_AW-1:`SXE_ADDR_LSB];
  wire [7:0] imm = instr_reg[`SXE_IMM_MSB:`SXE_IMM_LSB];
  wire [7:0] mval = dmem[maddr];
  wire [7:0] xor_m = acc_reg ^ mval;
  wire [7:0] xor_i = acc_reg ^ imm;

  // =============================================
  // apb decode
  // the answer comes one cycle into the access phase so that pready,
  // prdata and pslverr can all be flops
  wire acc_go = psel && penable && !pready;
  wire wr_go = acc_go && pwrite;
  wire is_mem = (paddr[11:10] == `SXE_MEM_BASE_SEL);
  wire [MEM_AW-1:0] bus_maddr = paddr[MEM_AW+1:2];
  wire is_busy = (state_reg != ST_IDLE);

  function is_reg;
    input [11:0] a;
    input [11:0] ofs;
    begin
      is_reg = (a == ofs);
    end
  endfunction

  // one select per register, decoded once and shared by the read mux,
  // the write paths and the error check
  wire sel_instr = is_reg(paddr, `SXE_OFS_INSTR);
  wire sel_acc = is_reg(paddr, `SXE_OFS_ACC);
  wire sel_status = is_reg(paddr, `SXE_OFS_STATUS);
  wire sel_tptr = is_reg(paddr, `SXE_OFS_TABLE_POINTER);
  wire sel_thigh = is_reg(paddr, `SXE_OFS_TABLE_HIGH);
  wire sel_page = is_reg(paddr, `SXE_OFS_PAGE);

  // instruction writes and memory writes collide with execution while busy;
  // they are refused with pslverr instead of queued, so the data memory
  // never sees two writers in one cycle
  wire bad_wr = wr_go && is_busy && (is_mem || sel_instr);
  wire issue = wr_go && !is_busy && sel_instr;
  wire unmapped = !is_mem && !sel_instr && !sel_acc && !sel_status &&
                  !sel_tptr && !sel_thigh && !sel_page;

  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0000_0000;
    if (is_mem) begin
      rd_next[7:0] = dmem[bus_maddr];
    end else if (sel_instr) begin
      rd_next[23:0] = instr_reg;
    end else if (sel_acc) begin
      rd_next[7:0] = acc_reg;
    end else if (sel_status) begin
      rd_next[`SXE_ST_ZERO] = zero_reg;
      rd_next[`SXE_ST_SKIP] = skip_next;
      rd_next[`SXE_ST_BUSY] = is_busy;
    end else if (sel_tptr) begin
      rd_next[7:0] = table_pointer_reg;
    end else if (sel_thigh) begin
      rd_next[7:0] = table_high_latch_reg;
    end else if (sel_page) begin
      rd_next[PAGE_W-1:0] = page_reg;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc_go;
      pslverr <= acc_go && (unmapped || bad_wr);
      if (acc_go && !pwrite) begin
        prdata <= rd_next;
      end
    end
  end

  // =============================================
  // data memory: one writer per cycle, the bus only while idle
  wire exec_mwr = (state_reg == ST_EXEC) && (op == `SXE_OP_XOR_TO_MEM);
  wire tab_mwr = (state_reg == ST_TDATA);
  always @(posedge pclk) begin
    if (exec_mwr) begin
      dmem[maddr] <= xor_m;
    end else if (tab_mwr) begin
      dmem[maddr] <= prog_rdata[7:0];
    end else if (wr_go && is_mem && !is_busy) begin
      dmem[bus_maddr] <= pwdata[7:0];
    end
  end

  // skip decision shared by the three skip tests; the bit test looks at one
  // bit, the other two at the whole byte, and none of them touches the zero flag
  function skip_test;
    input [3:0] code;
    input [7:0] data;
    input [2:0] pos;
    begin
      if (code == `SXE_OP_SZBIT) begin
        skip_test = !data[pos];
      end else begin
        skip_test = (data == 8'h00);
      end
    end
  endfunction

  wire skip_hit = skip_test(op, mval, bsel);

  // program word address: page bits above, table pointer below
  function [PAGE_W+7:0] table_addr;
    input [PAGE_W-1:0] page;
    input [7:0] ptr;
    begin
      table_addr = {page, ptr};
    end
  endfunction

  // =============================================
  // execution sequencer
  // one pclk stands for one instruction cycle; skip tests always spend a second
  // cycle whatever the outcome, and table reads spend a second and a third
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      instr_reg <= `SXE_RST_INSTR;
      acc_reg <= `SXE_RST_ACC;
      zero_reg <= 1'b0;
      table_pointer_reg <= `SXE_RST_TABLE_POINTER;
      table_high_latch_reg <= `SXE_RST_TABLE_HIGH;
      page_reg <= `SXE_RST_PAGE;
      prog_addr <= {(PAGE_W+8){1'b0}};
      prog_rd <= 1'b0;
      skip_next <= 1'b0;
      dummy_cycle <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (wr_go && !is_mem) begin
        if (sel_acc && !is_busy) begin
          acc_reg <= pwdata[7:0];
        end
        if (sel_status && !is_busy) begin
          zero_reg <= pwdata[`SXE_ST_ZERO];
        end
        if (sel_tptr) begin
          table_pointer_reg <= pwdata[7:0];
        end
        if (sel_page) begin
          page_reg <= pwdata[PAGE_W-1:0];
        end
      end
      case (state_reg)
        ST_IDLE: begin
          // skip_next of the last test stands until the next issue
          if (issue) begin
            instr_reg <= pwdata[23:0];
            state_reg <= ST_EXEC;
            busy <= 1'b1;
            skip_next <= 1'b0;
          end
        end
        ST_EXEC: begin
          state_reg <= ST_IDLE;
          busy <= 1'b0;
          case (op)
            `SXE_OP_SKIP_ZERO: begin
              skip_next <= skip_hit;
              dummy_cycle <= 1'b1;
              state_reg <= ST_DUMMY;
              busy <= 1'b1;
            end
            `SXE_OP_MOVE_SKIP: begin
              acc_reg <= mval;
              skip_next <= skip_hit;
              dummy_cycle <= 1'b1;
              state_reg <= ST_DUMMY;
              busy <= 1'b1;
            end
            `SXE_OP_SZBIT: begin
              skip_next <= skip_hit;
              dummy_cycle <= 1'b1;
              state_reg <= ST_DUMMY;
              busy <= 1'b1;
            end
            `SXE_OP_TRDC: begin
              prog_addr <= table_addr(page_reg, table_pointer_reg);
              prog_rd <= 1'b1;
              state_reg <= ST_TWAIT;
              busy <= 1'b1;
            end
            `SXE_OP_TRDL: begin
              prog_addr <= table_addr(LAST_PAGE, table_pointer_reg);
              prog_rd <= 1'b1;
              state_reg <= ST_TWAIT;
              busy <= 1'b1;
            end
            `SXE_OP_XORA: begin
              acc_reg <= xor_m;
              zero_reg <= (xor_m == 8'h00);
            end
            `SXE_OP_XOR_TO_MEM: begin
              zero_reg <= (xor_m == 8'h00);
            end
            `SXE_OP_XORI: begin
              acc_reg <= xor_i;
              zero_reg <= (xor_i == 8'h00);
            end
            default: begin
              skip_next <= 1'b0;
            end
          endcase
        end
        ST_DUMMY: begin
          // the skipped slot is filled by a no-op whether or not it skips
          dummy_cycle <= 1'b0;
          busy <= 1'b0;
          state_reg <= ST_IDLE;
        end
        ST_TWAIT: begin
          // the rom registers the word on this edge; it is taken one edge later
          prog_rd <= 1'b0;
          state_reg <= ST_TDATA;
        end
        ST_TDATA: begin
          table_high_latch_reg <= prog_rdata[15:8];
          busy <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
          busy <= 1'b0;
          dummy_cycle <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [verification/sxe_exec_properties.sv]
// sxe_exec_properties.sv: port checker for sxe_exec
// assumes: bound to sxe_exec, single clock pclk
`timescale 1ns/1ps
`default_nettype none
module sxe_exec_properties #(parameter PAGE_W = 5) (
  // clock, reset and bus
  input wire logic pclk, presetn, psel, penable, pready, pslverr,
  // program memory and fetch side
  input wire logic prog_rd, skip_next, dummy_cycle, busy,
  input wire logic [PAGE_W+7:0] prog_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // table read: strobe, rom edge, result edge
  sequence rom_cycle;
    prog_rd ##1 (!prog_rd && busy) ##1 !busy;
  endsequence
  sequence dummy_end;
    busy ##1 (!dummy_cycle && !busy);
  endsequence
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rom_steps: assert property (prog_rd |-> rom_cycle)
    else $error("table read steps wrong");
  a_addr_hold: assert property (prog_rd |=> $stable(prog_addr))
    else $error("rom address moved");
  a_rd_nodummy: assert property (prog_rd |-> busy && !dummy_cycle)
    else $error("table read with dummy");
  a_skip_dummy: assert property ($rose(skip_next) |-> dummy_cycle)
    else $error("skip without dummy");
  a_dummy_two: assert property (dummy_cycle |-> dummy_end)
    else $error("dummy cycle length wrong");
  a_busy_short: assert property ($rose(busy) |-> ##[1:3] !busy)
    else $error("busy too long");
  a_skip_hold: assert property (skip_next && !busy |=> skip_next || busy)
    else $error("skip flag dropped");
endmodule
bind sxe_exec sxe_exec_properties #(.PAGE_W(PAGE_W)) i_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prog_rd(prog_rd), .skip_next(skip_next),
  .dummy_cycle(dummy_cycle), .busy(busy), .prog_addr(prog_addr));
`default_nettype wire

// [verification/sxe_prog_rom.sv]
// sxe_prog_rom.sv: program memory model for sxe_exec
// assumes: same clock, word valid one cycle after a read strobe
`timescale 1ns/1ps
`default_nettype none
module sxe_prog_rom (
  // ====
  // rom port
  input wire logic pclk,
  input wire logic prog_rd,
  input wire logic [12:0] prog_addr,
  output logic [15:0] prog_rdata
);
  // high byte names the page, low byte the pointer xor c3; inverted when stale
  always @(posedge pclk) begin
    if (prog_rd)
      prog_rdata <= {3'h0, prog_addr[12:8], prog_addr[7:0] ^ 8'hc3};
    else
      prog_rdata <= ~prog_rdata;
  end
endmodule
`default_nettype wire

// [verification/test_skip_table_xor_exec.sv]
// test_skip_table_xor_exec.sv: self-checking bench for sxe_exec
// assumes: rom model on the program port, registers over apb
`timescale 1ns/1ps
`default_nettype none
module test_skip_table_xor_exec;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, prog_rd, skip_next, dummy_cycle, busy;
  logic [12:0] prog_addr, seen_addr;
  logic [15:0] prog_rdata;
  int failures = 0, compares = 0, dummies = 0, d0;
  sxe_exec i_sxe_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .prog_rdata(prog_rdata), .skip_next(skip_next),
    .dummy_cycle(dummy_cycle), .busy(busy));
  sxe_prog_rom i_sxe_prog_rom (.pclk(pclk), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .prog_rdata(prog_rdata));
  always #12.5 pclk = ~pclk;
  // ====
  // monitors
  always @(posedge pclk) begin
    if (dummy_cycle === 1'b1) dummies <= dummies + 1;
    if (prog_rd === 1'b1) seen_addr <= prog_addr;
  end
  task check(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    check(pslverr, err);
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d, 0);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, '0, 0);
    check(rd, e);
  endtask
  function logic [11:0] mem(input logic [7:0] m);
    return {2'b01, m, 2'b00};
  endfunction
  // issue, then poll busy: no new instruction while one runs
  task exec(input logic [3:0] op, input logic [2:0] b, input logic [7:0] m, imm);
    wr(12'h000, {8'h00, imm, m, 1'b0, b, op});
    do apb(0, 12'h008, '0, 0); while (rd[2] !== 1'b0);
    check(busy, 0);
  endtask
  // ====
  // scenarios
  task t_skip;
    wr(mem(5), 0); wr(mem(6), 32'h10); wr(12'h008, 1);
    d0 = dummies;
    exec(0, 0, 5, 0); rdchk(12'h008, 32'h3);
    check(skip_next, 1);
    exec(0, 0, 6, 0); rdchk(12'h008, 32'h1);
    check(skip_next, 0);
    exec(1, 0, 6, 0); rdchk(12'h004, 32'h10);
    rdchk(12'h008, 32'h1);
    exec(1, 0, 5, 0); rdchk(12'h004, 0);
    rdchk(12'h008, 32'h3);
    exec(2, 4, 6, 0); rdchk(12'h008, 32'h1);
    exec(2, 3, 6, 0); rdchk(12'h008, 32'h3);
    check(dummies - d0, 6);
  endtask
  task t_table;
    wr(12'h00c, 32'h34); wr(12'h014, 32'h02);
    exec(3, 0, 7, 0); check(seen_addr, 13'h0234);
    rdchk(mem(7), 32'hf7); rdchk(12'h010, 32'h02);
    exec(4, 0, 9, 0); check(seen_addr, 13'h1f34);
    rdchk(mem(9), 32'hf7); rdchk(12'h010, 32'h1f);
    rdchk(12'h008, 32'h1);
  endtask
  task t_xor;
    wr(12'h004, 32'h3c); wr(mem(8), 32'h3c);
    exec(5, 0, 8, 0); rdchk(12'h004, 0);
    rdchk(12'h008, 1);
    wr(12'h004, 32'h0f); wr(mem(8), 32'hf0);
    exec(6, 0, 8, 0); rdchk(mem(8), 32'hff);
    rdchk(12'h004, 32'h0f); rdchk(12'h008, 0);
    exec(7, 0, 0, 8'h0f); rdchk(12'h004, 0);
    rdchk(12'h008, 1);
    apb(0, 12'h0f0, '0, 1);
  endtask
  task conclude;
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_skip;
    t_table;
    t_xor;
    conclude;
  end
  initial begin
    #100000;
    failures++;
    conclude;
  end
endmodule
`default_nettype wire
